// *** rtl/timer_ch34_consts.vh ***
// Constants for the channel 3/4 mode configuration block
`ifndef TIMER_CH34_CONSTS_VH
`define TIMER_CH34_CONSTS_VH
`define MODE_REG_ADDR 8'h1C
`define ENABLE_REG_ADDR 8'h20
`define TRIGGER_REG_ADDR 8'h24
`define CAPTURE_REG_ADDR 8'h28
`define MODE_REG_RESET 16'h0000
`define CH3_SEL_LSB 0
`define CH4_SEL_LSB 8
`define CH3_ENABLE_BIT 8
`define CH4_ENABLE_BIT 12
`define CH3_CLEAR_BIT 7
`define CH3_MODE_LSB 4
`define CH3_PRELOAD_BIT 3
`define CH3_FAST_BIT 2
`define CH3_FILTER_LSB 4
`define CH3_PRESCALER_LSB 2
`define CH4_CLEAR_BIT 15
`define CH4_MODE_LSB 12
`define CH4_PRELOAD_BIT 11
`define CH4_FAST_BIT 10
`define CH4_FILTER_LSB 12
`define CH4_PRESCALER_LSB 10
`define SEL_OUTPUT 2'h0
`define SEL_OWN_PIN 2'h1
`define SEL_NEIGHBOUR_PIN 2'h2
`define SEL_TRIGGER 2'h3
`define MODE_PWM1 3'h6
`define MODE_PWM2 3'h7
`define TRIG_INTERNAL_MAX 3'h3
`define DEAD_TIME_DIV 8'h01
`endif

// *** rtl/input_channel.v ***
// One capture input channel: filter, edge detect and prescaler
`timescale 1ns/1ps
module input_channel (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Control
  input wire enable_in,
  input wire dts_tick_in,
  input wire [3:0] filter_in,
  input wire [1:0] prescaler_in,
  input wire sample_in,
  // Result
  output reg filtered_out,
  output reg capture_out
);
  reg [4:0] div_count;
  reg [3:0] stable_count;
  reg last_level;
  reg [2:0] event_count;
  reg [4:0] div_limit;
  reg [3:0] need;
  wire tick;
  wire rise;
  // --------------------------------------------------------------------
  // Filter code decode
  // --------------------------------------------------------------------
  always @* begin
    div_limit = 5'h00;
    need = 4'h1;
    case (filter_in)
      4'h0: begin div_limit = 5'h00; need = 4'h1; end
      4'h1: begin div_limit = 5'h00; need = 4'h2; end
      4'h2: begin div_limit = 5'h00; need = 4'h4; end
      4'h3: begin div_limit = 5'h00; need = 4'h8; end
      4'h4: begin div_limit = 5'h01; need = 4'h6; end
      4'h5: begin div_limit = 5'h01; need = 4'h8; end
      4'h6: begin div_limit = 5'h03; need = 4'h6; end
      4'h7: begin div_limit = 5'h03; need = 4'h8; end
      4'h8: begin div_limit = 5'h07; need = 4'h6; end
      4'h9: begin div_limit = 5'h07; need = 4'h8; end
      4'hA: begin div_limit = 5'h0F; need = 4'h5; end
      4'hB: begin div_limit = 5'h0F; need = 4'h6; end
      4'hC: begin div_limit = 5'h0F; need = 4'h8; end
      4'hD: begin div_limit = 5'h1F; need = 4'h5; end
      4'hE: begin div_limit = 5'h1F; need = 4'h6; end
      default: begin div_limit = 5'h1F; need = 4'h8; end
    endcase
  end
  // Codes 1..3 sample every clock, others at divided dead-time rate
  assign tick = (filter_in == 4'h1 || filter_in == 4'h2 || filter_in == 4'h3) ? 1'b1 :
                (dts_tick_in && div_count == div_limit);
  // --------------------------------------------------------------------
  // Sample divider and consistency counter
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_count <= 5'h00;
      stable_count <= 4'h0;
      filtered_out <= 1'b0;
    end else begin
      if (dts_tick_in) begin
        div_count <= (div_count >= div_limit) ? 5'h00 : div_count + 5'h01;
      end
      if (tick) begin
        if (sample_in == filtered_out) begin
          stable_count <= 4'h0;
        end else if (stable_count + 4'h1 >= need) begin
          filtered_out <= sample_in;
          stable_count <= 4'h0;
        end else begin
          stable_count <= stable_count + 4'h1;
        end
      end
    end
  end
  // --------------------------------------------------------------------
  // Edge detect and capture prescaler
  // --------------------------------------------------------------------
  assign rise = filtered_out && !last_level;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_level <= 1'b0;
      event_count <= 3'h0;
      capture_out <= 1'b0;
    end else begin
      last_level <= filtered_out;
      capture_out <= 1'b0;
      if (!enable_in) begin
        event_count <= 3'h0;
      end else if (rise) begin
        case (prescaler_in)
          2'h0: capture_out <= 1'b1;
          2'h1: capture_out <= (event_count[0] == 1'b1);
          2'h2: capture_out <= (event_count[1:0] == 2'h3);
          default: capture_out <= (event_count == 3'h7);
        endcase
        event_count <= event_count + 3'h1;
      end
    end
  end
endmodule // input_channel

// *** rtl/timer_ch34_mode.v ***
// Channel 3/4 mode register with AHB-Lite slave and input routing
//
// Summary of operation
// - Channel 4 selection 00 at bits 9:8 makes channel 4 an output-compare channel.
// - Channel 4 selection 01 takes capture input 4 from pin 4, 10 from pin 3.
// - Channel 4 selection 11 takes capture input 4 from the internal trigger, only when an internal trigger is chosen.
// - Channel 4 selection is written only while channel 4 is disabled.
// - Channel 3 selection 00 at bits 1:0 makes channel 3 an output-compare channel.
// - Channel 3 selection 01 takes capture input 3 from pin 3, 10 from pin 4.
// - Channel 3 selection 11 takes capture input 3 from the internal trigger, only when an internal trigger is chosen.
// - Channel 3 selection is written only while channel 3 is disabled.
// - Channel 4 output fields are clear enable 15, mode 14:12, preload 11, fast 10.
// - Channel 3 output fields are clear enable 7, mode 6:4, preload 3, fast 2.
// - Channel 4 input fields are filter 15:12 and prescaler 11:10.
// - Channel 3 input fields are filter 7:4 and prescaler 3:2.
// - The mode register sits at offset 0x1C and resets to 0x0000.
// - The prescaler captures every 1, 2, 4 or 8 events and resets while the channel is off.
// - The filter changes its output only after N consistent samples, code 0000 meaning none.
// - Fast enable acts only in the two PWM compare modes.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "timer_ch34_consts.vh"
module timer_ch34_mode #(
  parameter DTS_DIV = `DEAD_TIME_DIV
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [7:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire hready_in,
  input wire [31:0] hwdata_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // Timer input pins
  input wire timer_input_pin_3_in,
  input wire timer_input_pin_4_in,
  input wire internal_trigger_source_in,
  // Output compare settings
  output reg ch3_output_mode_out,
  output reg ch4_output_mode_out,
  output reg ch3_ref_clear_enable_out,
  output reg [2:0] ch3_compare_mode_out,
  output reg ch3_preload_enable_out,
  output reg ch3_fast_active_out,
  output reg ch4_ref_clear_enable_out,
  output reg [2:0] ch4_compare_mode_out,
  output reg ch4_preload_enable_out,
  output reg ch4_fast_active_out,
  // Capture results
  output reg capture_input_3_out,
  output reg capture_input_4_out,
  output reg ch3_capture_out,
  output reg ch4_capture_out
);
  reg [15:0] channel_3_4_mode;
  reg [15:0] channel_enable_register;
  reg [2:0] trigger_source_select;
  reg [1:0] capture_flags;
  reg wr_pending;
  reg [7:0] wr_addr;
  reg [1:0] pin3_sync;
  reg [1:0] pin4_sync;
  reg [1:0] trig_sync;
  reg [7:0] dts_count;
  reg dts_tick;
  reg [15:0] next_mode;
  wire ch3_capture;
  wire ch4_capture;
  wire ch3_filtered;
  wire ch4_filtered;
  wire ch3_enable;
  wire ch4_enable;
  wire trigger_internal;
  wire [1:0] ch3_sel;
  wire [1:0] ch4_sel;
  wire route3;
  wire route4;
  wire ch3_input_mode;
  wire ch4_input_mode;
  wire ch3_ref_clear_enable;
  wire [2:0] ch3_compare_mode;
  wire ch3_preload_enable;
  wire ch3_fast_enable;
  wire ch3_fast_active;
  wire [3:0] ch3_input_filter;
  wire [1:0] ch3_capture_prescaler;
  wire ch4_ref_clear_enable;
  wire [2:0] ch4_compare_mode;
  wire ch4_preload_enable;
  wire ch4_fast_enable;
  wire ch4_fast_active;
  wire [3:0] ch4_input_filter;
  wire [1:0] ch4_capture_prescaler;
  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  function route_input;
    input [1:0] sel;
    input own_pin;
    input neighbour_pin;
    input trig;
    input trig_ok;
    begin
      case (sel)
        `SEL_OWN_PIN: route_input = own_pin;
        `SEL_NEIGHBOUR_PIN: route_input = neighbour_pin;
        `SEL_TRIGGER: route_input = trig & trig_ok;
        default: route_input = 1'b0;
      endcase
    end
  endfunction
  function fast_active;
    input [2:0] mode;
    input fast;
    begin
      fast_active = fast && (mode == `MODE_PWM1 || mode == `MODE_PWM2);
    end
  endfunction
  // --------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------
  assign ch3_sel = channel_3_4_mode[`CH3_SEL_LSB+1:`CH3_SEL_LSB];
  assign ch4_sel = channel_3_4_mode[`CH4_SEL_LSB+1:`CH4_SEL_LSB];
  assign ch3_enable = channel_enable_register[`CH3_ENABLE_BIT];
  assign ch4_enable = channel_enable_register[`CH4_ENABLE_BIT];
  assign trigger_internal = (trigger_source_select <= `TRIG_INTERNAL_MAX);
  assign route3 = route_input(ch3_sel, pin3_sync[1], pin4_sync[1], trig_sync[1], trigger_internal);
  assign route4 = route_input(ch4_sel, pin4_sync[1], pin3_sync[1], trig_sync[1], trigger_internal);
  // --------------------------------------------------------------------
  // Named fields of the shared mode storage
  // --------------------------------------------------------------------
  assign ch3_input_mode = (ch3_sel != `SEL_OUTPUT);
  assign ch4_input_mode = (ch4_sel != `SEL_OUTPUT);
  assign ch3_ref_clear_enable = channel_3_4_mode[`CH3_CLEAR_BIT];
  assign ch3_compare_mode = channel_3_4_mode[`CH3_MODE_LSB+2:`CH3_MODE_LSB];
  assign ch3_preload_enable = channel_3_4_mode[`CH3_PRELOAD_BIT];
  assign ch3_fast_enable = channel_3_4_mode[`CH3_FAST_BIT];
  assign ch3_fast_active = fast_active(ch3_compare_mode, ch3_fast_enable);
  assign ch3_input_filter = channel_3_4_mode[`CH3_FILTER_LSB+3:`CH3_FILTER_LSB];
  assign ch3_capture_prescaler = channel_3_4_mode[`CH3_PRESCALER_LSB+1:`CH3_PRESCALER_LSB];
  assign ch4_ref_clear_enable = channel_3_4_mode[`CH4_CLEAR_BIT];
  assign ch4_compare_mode = channel_3_4_mode[`CH4_MODE_LSB+2:`CH4_MODE_LSB];
  assign ch4_preload_enable = channel_3_4_mode[`CH4_PRELOAD_BIT];
  assign ch4_fast_enable = channel_3_4_mode[`CH4_FAST_BIT];
  assign ch4_fast_active = fast_active(ch4_compare_mode, ch4_fast_enable);
  assign ch4_input_filter = channel_3_4_mode[`CH4_FILTER_LSB+3:`CH4_FILTER_LSB];
  assign ch4_capture_prescaler = channel_3_4_mode[`CH4_PRESCALER_LSB+1:`CH4_PRESCALER_LSB];
  // --------------------------------------------------------------------
  // Write merge with selection lock
  // --------------------------------------------------------------------
  always @* begin
    next_mode = hwdata_in[15:0];
    if (ch3_enable) begin
      next_mode[`CH3_SEL_LSB+1:`CH3_SEL_LSB] = ch3_sel;
    end
    if (ch4_enable) begin
      next_mode[`CH4_SEL_LSB+1:`CH4_SEL_LSB] = ch4_sel;
    end
  end
  // --------------------------------------------------------------------
  // Input synchronisers and dead-time divider
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin3_sync <= 2'h0;
      pin4_sync <= 2'h0;
      trig_sync <= 2'h0;
      dts_count <= 8'h00;
      dts_tick <= 1'b0;
    end else begin
      pin3_sync <= {pin3_sync[0], timer_input_pin_3_in};
      pin4_sync <= {pin4_sync[0], timer_input_pin_4_in};
      trig_sync <= {trig_sync[0], internal_trigger_source_in};
      dts_tick <= (dts_count == 8'h00);
      dts_count <= (dts_count + 8'h01 >= DTS_DIV[7:0]) ? 8'h00 : dts_count + 8'h01;
    end
  end
  // --------------------------------------------------------------------
  // Capture channels
  // --------------------------------------------------------------------
  input_channel u_ch3 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(ch3_enable && ch3_input_mode),
    .dts_tick_in(dts_tick),
    .filter_in(ch3_input_filter),
    .prescaler_in(ch3_capture_prescaler),
    .sample_in(route3),
    .filtered_out(ch3_filtered),
    .capture_out(ch3_capture)
  );
  input_channel u_ch4 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(ch4_enable && ch4_input_mode),
    .dts_tick_in(dts_tick),
    .filter_in(ch4_input_filter),
    .prescaler_in(ch4_capture_prescaler),
    .sample_in(route4),
    .filtered_out(ch4_filtered),
    .capture_out(ch4_capture)
  );
  // --------------------------------------------------------------------
  // AHB-Lite slave and registers
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      channel_3_4_mode <= `MODE_REG_RESET;
      channel_enable_register <= 16'h0000;
      trigger_source_select <= 3'h0;
      capture_flags <= 2'h0;
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pending <= 1'b0;
      if (wr_pending) begin
        case (wr_addr)
          `MODE_REG_ADDR: channel_3_4_mode <= next_mode;
          `ENABLE_REG_ADDR: channel_enable_register <= hwdata_in[15:0] & 16'h3FFF;
          `TRIGGER_REG_ADDR: trigger_source_select <= hwdata_in[2:0];
          default: ;
        endcase
      end
      // Set wins over read clear
      capture_flags <= capture_flags | {ch4_capture, ch3_capture};
      if (hsel_in && hready_in && htrans_in[1]) begin
        if (hwrite_in) begin
          wr_pending <= 1'b1;
          wr_addr <= {haddr_in[7:2], 2'h0};
        end else begin
          case ({haddr_in[7:2], 2'h0})
            `MODE_REG_ADDR: hrdata_out <= {16'h0000, channel_3_4_mode};
            `ENABLE_REG_ADDR: hrdata_out <= {16'h0000, channel_enable_register};
            `TRIGGER_REG_ADDR: hrdata_out <= {29'h00000000, trigger_source_select};
            `CAPTURE_REG_ADDR: begin
              hrdata_out <= {28'h0000000, ch4_filtered, ch3_filtered, capture_flags};
              capture_flags <= {ch4_capture, ch3_capture};
            end
            default: hrdata_out <= 32'h00000000;
          endcase
        end
      end
    end
  end
  // --------------------------------------------------------------------
  // Registered decode outputs
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ch3_output_mode_out <= 1'b1;
      ch4_output_mode_out <= 1'b1;
      ch3_ref_clear_enable_out <= 1'b0;
      ch3_compare_mode_out <= 3'h0;
      ch3_preload_enable_out <= 1'b0;
      ch3_fast_active_out <= 1'b0;
      ch4_ref_clear_enable_out <= 1'b0;
      ch4_compare_mode_out <= 3'h0;
      ch4_preload_enable_out <= 1'b0;
      ch4_fast_active_out <= 1'b0;
      capture_input_3_out <= 1'b0;
      capture_input_4_out <= 1'b0;
      ch3_capture_out <= 1'b0;
      ch4_capture_out <= 1'b0;
    end else begin
      ch3_output_mode_out <= !ch3_input_mode;
      ch4_output_mode_out <= !ch4_input_mode;
      // Output view only when the channel is an output
      if (!ch3_input_mode) begin
        ch3_ref_clear_enable_out <= ch3_ref_clear_enable;
        ch3_compare_mode_out <= ch3_compare_mode;
        ch3_preload_enable_out <= ch3_preload_enable;
        ch3_fast_active_out <= ch3_fast_active;
      end else begin
        ch3_ref_clear_enable_out <= 1'b0;
        ch3_compare_mode_out <= 3'h0;
        ch3_preload_enable_out <= 1'b0;
        ch3_fast_active_out <= 1'b0;
      end
      if (!ch4_input_mode) begin
        ch4_ref_clear_enable_out <= ch4_ref_clear_enable;
        ch4_compare_mode_out <= ch4_compare_mode;
        ch4_preload_enable_out <= ch4_preload_enable;
        ch4_fast_active_out <= ch4_fast_active;
      end else begin
        ch4_ref_clear_enable_out <= 1'b0;
        ch4_compare_mode_out <= 3'h0;
        ch4_preload_enable_out <= 1'b0;
        ch4_fast_active_out <= 1'b0;
      end
      capture_input_3_out <= ch3_filtered;
      capture_input_4_out <= ch4_filtered;
      ch3_capture_out <= ch3_capture;
      ch4_capture_out <= ch4_capture;
    end
  end
endmodule // timer_ch34_mode

// *** test/timer_ch34_mode_sva.sv ***
// Assertion checker for the channel 3/4 mode block
`timescale 1ns/1ps
module timer_ch34_mode_chk (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Bus
  input wire hsel_in,
  input wire [7:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire hready_in,
  input wire [31:0] hrdata_out,
  input wire hreadyout_out,
  input wire hresp_out,
  // Channel view
  input wire ch3_output_mode_out,
  input wire ch4_output_mode_out,
  input wire ch3_ref_clear_enable_out,
  input wire [2:0] ch3_compare_mode_out,
  input wire ch3_preload_enable_out,
  input wire ch3_fast_active_out,
  input wire [2:0] ch4_compare_mode_out,
  input wire ch4_fast_active_out,
  input wire capture_input_3_out,
  input wire ch3_capture_out,
  input wire ch4_capture_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire taken;
  wire wr_mode;
  assign taken = hsel_in && hready_in && htrans_in[1];
  assign wr_mode = taken && hwrite_in && haddr_in == 8'h1C;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  bus_okay_a: assert property (hreadyout_out && !hresp_out)
    else $error("bus slave not ready or not okay");
  reset_view_a: assert property ($rose(rst_n_in) |-> ch3_output_mode_out && ch4_output_mode_out &&
    ch3_compare_mode_out == 3'h0) else $error("view not at reset state");
  unmapped_zero_a: assert property (taken && !hwrite_in && haddr_in > 8'h28 |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (taken && !hwrite_in && haddr_in == 8'h1C |=> hrdata_out[31:16] == 16'h0)
    else $error("upper half of mode read not zero");
  input_view_a: assert property (!ch3_output_mode_out |-> !ch3_ref_clear_enable_out &&
    ch3_compare_mode_out == 3'h0 && !ch3_preload_enable_out && !ch3_fast_active_out)
    else $error("output fields shown in input mode");
  fast_ch3_a: assert property (ch3_fast_active_out |-> ch3_compare_mode_out[2:1] == 2'h3)
    else $error("ch3 fast outside pwm modes");
  fast_ch4_a: assert property (ch4_fast_active_out |-> ch4_compare_mode_out[2:1] == 2'h3)
    else $error("ch4 fast outside pwm modes");
  pulse_once_a: assert property (ch3_capture_out |=> !ch3_capture_out)
    else $error("ch3 capture pulse too long");
  pulse_ch4_a: assert property (ch4_capture_out |=> !ch4_capture_out)
    else $error("ch4 capture pulse too long");
  capture_cause_a: assert property (ch3_capture_out |-> !ch3_output_mode_out &&
    (capture_input_3_out || $past(capture_input_3_out))) else $error("capture without input edge");
  mode_cause_a: assert property ($changed(ch3_output_mode_out) |-> $past(wr_mode, 2) || $past(wr_mode, 3))
    else $error("direction changed without a write");
  // ----------------------------------------
  // Covers
  // ----------------------------------------
  cover property (ch3_capture_out);
  cover property (ch4_capture_out);
  cover property (ch4_fast_active_out);
  cover property (taken && !hwrite_in && haddr_in > 8'h28);
endmodule // timer_ch34_mode_chk

// *** test/tb.sv ***
// Testbench for the channel 3/4 mode block
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_in, rst_n_in, hsel_in, hwrite_in, pin3, pin4, trig, rd_valid, e3, e4;
  logic [7:0] haddr_in;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in, ts;
  logic [31:0] hwdata_in, rnd_state;
  logic [15:0] v;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out, om3, om4, rc3, pe3, fa3, rc4, pe4, fa4, ci3, ci4, cap3, cap4;
  wire [2:0] cm3, cm4;
  logic [31:0] exp_q[$];
  int failures, samples_checked, n3, n4;

  timer_ch34_mode i_timer_ch34_mode (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hready_in(hreadyout_out), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .timer_input_pin_3_in(pin3), .timer_input_pin_4_in(pin4),
    .internal_trigger_source_in(trig), .ch3_output_mode_out(om3), .ch4_output_mode_out(om4),
    .ch3_ref_clear_enable_out(rc3), .ch3_compare_mode_out(cm3), .ch3_preload_enable_out(pe3),
    .ch3_fast_active_out(fa3), .ch4_ref_clear_enable_out(rc4), .ch4_compare_mode_out(cm4),
    .ch4_preload_enable_out(pe4), .ch4_fast_active_out(fa4), .capture_input_3_out(ci3),
    .capture_input_4_out(ci4), .ch3_capture_out(cap3), .ch4_capture_out(cap4));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= wr;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    rd_valid <= !wr;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rd_valid <= 1'b0;
    @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task give_verdict;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (rd_valid === 1'b1 && hreadyout_out === 1'b1) begin
      check(hrdata_out, exp_q.pop_front());
    end
    if (cap3 === 1'b1) n3++;
    if (cap4 === 1'b1) n4++;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    give_verdict;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {rst_n_in, hsel_in, hwrite_in, pin3, pin4, trig, rd_valid} = 7'h00;
    {haddr_in, htrans_in, hwdata_in} = 42'h0;
    hsize_in = 3'h2;
    rnd_state = 32'h297B1EA6;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd(8'h1C, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    // Output view in every compare mode
    for (int i = 0; i < 8; i++) begin
      rnd_state = xs(rnd_state);
      v = {rnd_state[15], i[2:0], rnd_state[11:10], 2'h0, rnd_state[7], i[2:0], rnd_state[3:2], 2'h0};
      wr(8'h1C, {16'hFFFF, v});
      rd(8'h1C, {16'h0, v});
      check({om4, rc4, cm4, pe4, fa4, om3, rc3, cm3, pe3, fa3},
        {1'b1, v[15:11], v[10] & (i > 5), 1'b1, v[7:3], v[2] & (i > 5)});
    end
    // Capture routing for every input selection
    for (int s = 1; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        rnd_state = xs(rnd_state);
        ts = {k[0], rnd_state[21:20]};
        wr(8'h24, {29'h0, ts});
        wr(8'h1C, {20'h0, rnd_state[11:10], s[1:0], 4'h0, rnd_state[3:2], s[1:0]});
        pin3 <= rnd_state[16];
        pin4 <= rnd_state[17];
        trig <= rnd_state[18];
        e3 = (s == 1) ? rnd_state[16] : (s == 2) ? rnd_state[17] : rnd_state[18] & !k[0];
        e4 = (s == 1) ? rnd_state[17] : (s == 2) ? rnd_state[16] : rnd_state[18] & !k[0];
        repeat (10) @(posedge clk_in);
        check({om3, om4, rc3, cm3, pe3, fa3, ci3, ci4}, {8'h0, e3, e4});
      end
    end
    // Selection locked while a channel is enabled
    pin3 <= 1'b0;
    pin4 <= 1'b0;
    wr(8'h1C, 32'h0101);
    wr(8'h20, 32'h1100);
    rd(8'h20, 32'h1100);
    wr(8'h1C, 32'hA3A3);
    rd(8'h1C, 32'hA1A1);
    wr(8'h20, 32'h0100);
    wr(8'h1C, 32'h0202);
    rd(8'h1C, 32'h0201);
    // Capture prescaler ratios
    for (int p = 0; p < 4; p++) begin
      wr(8'h20, 32'h0);
      wr(8'h1C, {20'h0, p[1:0], 2'h1, 4'h0, p[1:0], 2'h1});
      wr(8'h20, 32'h1100);
      n3 = 0;
      n4 = 0;
      repeat (8) begin
        pin3 <= 1'b1;
        pin4 <= 1'b1;
        repeat (6) @(posedge clk_in);
        pin3 <= 1'b0;
        pin4 <= 1'b0;
        repeat (6) @(posedge clk_in);
      end
      check(n3, 8 >> p);
      check(n4, 8 >> p);
    end
    // Filter of eight samples drops a short pulse and passes a long one
    wr(8'h20, 32'h0);
    wr(8'h1C, 32'h3131);
    wr(8'h20, 32'h1100);
    n3 = 0;
    n4 = 0;
    pin3 <= 1'b1;
    pin4 <= 1'b1;
    repeat (6) @(posedge clk_in);
    pin3 <= 1'b0;
    repeat (6) @(posedge clk_in);
    pin4 <= 1'b0;
    repeat (12) @(posedge clk_in);
    check(n3, 0);
    check(n4, 1);
    // Reset in mid-run
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd(8'h1C, 32'h0);
    give_verdict;
  end
endmodule // tb

bind timer_ch34_mode timer_ch34_mode_chk i_timer_ch34_mode_chk (.clk_in, .rst_n_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .ch3_output_mode_out,
  .ch4_output_mode_out, .ch3_ref_clear_enable_out, .ch3_compare_mode_out, .ch3_preload_enable_out,
  .ch3_fast_active_out, .ch4_compare_mode_out, .ch4_fast_active_out, .capture_input_3_out,
  .ch3_capture_out, .ch4_capture_out);
